// ==== core/osps_params.svh ====
`ifndef OSPS_PARAMS_SVH
`define OSPS_PARAMS_SVH

// Program store geometry and field widths.
`define OSPS_NUM_LOCS 40
`define OSPS_LOC_W 6
`define OSPS_VAL_W 16
`define OSPS_CMD_W 6

// Dwell is a count of 10 ms ticks; one tick is the shortest dwell.
`define OSPS_DWELL_MIN 16'h0001
`define OSPS_DWELL_TICK_NS 10000000
`define OSPS_CLK_PERIOD_NS 4
`define OSPS_TICK_CYCLES (`OSPS_DWELL_TICK_NS / `OSPS_CLK_PERIOD_NS)

// Register byte offsets on the APB port.
`define OSPS_CMD_OFS 8'h00
`define OSPS_STATUS_OFS 8'h04
`define OSPS_START_OFS 8'h08
`define OSPS_EDIT_OFS 8'h0C
`define OSPS_SETPT_OFS 8'h10
`define OSPS_LIMIT_OFS 8'h14
`define OSPS_DWNXT_OFS 8'h18

// Command register bit positions and the entered-location field.
`define OSPS_CMD_RUN 0
`define OSPS_CMD_STEP 1
`define OSPS_CMD_ENTER 2
`define OSPS_CMD_CLEAR 3
`define OSPS_CMD_RESET 4
`define OSPS_CMD_OUTTOG 5
`define OSPS_LOC_LSB 16

// Power-on defaults.
`define OSPS_START_RST 6'h01
`define OSPS_DEF_VSET 16'h0000
`define OSPS_DEF_ISET 16'h0000
`define OSPS_DEF_OV 16'hFFFF
`define OSPS_DEF_OC 16'hFFFF
`define OSPS_DEF_OUT_EN 1'b1

`endif

// ==== core/osps_pkg.sv ====
`include "osps_params.svh"

package osps_pkg;

    typedef enum logic [4:0] {
        OSPS_IDLE = 5'b00001,
        OSPS_PROMPT = 5'b00010,
        OSPS_RUN = 5'b00100,
        OSPS_STEP = 5'b01000,
        OSPS_HALT = 5'b10000
    } osps_state_t;

    typedef struct packed {
        logic [`OSPS_VAL_W-1:0] overvoltage_limit;
        logic [`OSPS_VAL_W-1:0] overcurrent_limit;
        logic [`OSPS_VAL_W-1:0] iset;
        logic [`OSPS_VAL_W-1:0] vset;
    } osps_setpt_t;

    typedef struct packed {
        logic [`OSPS_LOC_W-1:0] next_loc;
        logic [`OSPS_VAL_W-1:0] step_dwell_time;
        osps_setpt_t sp;
    } osps_step_t;

    typedef struct packed {
        logic [`OSPS_VAL_W-1:0] v;
        logic [`OSPS_VAL_W-1:0] i;
        logic constant_voltage_indicator;
        logic constant_current_indicator;
    } osps_meas_t;

    typedef struct packed {
        logic running_msg;
        logic local_ind;
        logic [`OSPS_LOC_W-1:0] exec_loc;
        logic [`OSPS_LOC_W-1:0] next_loc;
        osps_meas_t meas;
    } osps_disp_t;

    typedef struct packed {
        osps_state_t state;
        logic step_mode;
        logic stop_pend;
        logic [`OSPS_LOC_W-1:0] prompt_loc;
        logic [`OSPS_LOC_W-1:0] cur_loc;
        logic [`OSPS_VAL_W-1:0] dwell;
        logic [31:0] tick;
        logic [`OSPS_LOC_W-1:0] start_loc;
        logic [`OSPS_LOC_W-1:0] edit_loc;
        osps_setpt_t out;
        logic out_en;
        osps_disp_t disp;
        logic [`OSPS_CMD_W-1:0] cmd;
        logic [`OSPS_LOC_W-1:0] cmd_loc;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } osps_regs_t;

endpackage

// ==== core/osps_sequencer.sv ====
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "osps_params.svh"

// Contract
// - Step applies set-points and limits, holds dwell
// - Dwell timing within one percent
// - Run shows measurements, or message if minimal
// - Step display: local, locations, mode, measurements
// - Output on/off usable inside step mode
// - Successor pointing back loops indefinitely
// - Zero successor ends program after step
// - Ended program keeps final set-points
// - Clear in run finishes step, then stops
// - Reset in run stops now, restores defaults
// - Output toggle zeroes output, halts, remembers step
// - Second toggle restores remembered step values
// - Forty locations, dwell defaults to minimum
// - Dwell outside allowed span refused
module osps_sequencer
    import osps_pkg::*;
#(
    parameter int TICK_CYCLES = `OSPS_TICK_CYCLES,
    parameter int NUM_LOCS = `OSPS_NUM_LOCS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire osps_meas_t meas,
    output osps_setpt_t out_setpt,
    output logic out_enable,
    output osps_disp_t disp,
    output osps_state_t seq_state
);

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    osps_regs_t q, d;
    osps_step_t mem [0:NUM_LOCS];
    logic we_setpt, we_limit, we_dwnxt;
    logic all_min, load, wr_done;
    logic [`OSPS_LOC_W-1:0] load_loc;
    osps_step_t cur, nxt;

    // A location is usable only between one and the store size.
    function automatic logic loc_ok(input logic [`OSPS_LOC_W-1:0] l);
        loc_ok = (l != '0) && (32'(l) <= NUM_LOCS);
    endfunction

    // Bad writes: a dwell of zero or a successor beyond the store.
    // Successor zero is legal and ends the program.
    function automatic logic wr_bad(input logic [7:0] a,
                                    input logic [31:0] w);
        wr_bad = (a == `OSPS_DWNXT_OFS) &&
                 ((w[15:0] < `OSPS_DWELL_MIN) ||
                  (32'(w[`OSPS_LOC_LSB +: `OSPS_LOC_W]) > NUM_LOCS));
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == `OSPS_CMD_OFS) || (a == `OSPS_STATUS_OFS) ||
                  (a == `OSPS_START_OFS) || (a == `OSPS_EDIT_OFS) ||
                  (a == `OSPS_SETPT_OFS) || (a == `OSPS_LIMIT_OFS) ||
                  (a == `OSPS_DWNXT_OFS);
    endfunction

    // Shortest-dwell detection feeds the running message.
    always_comb begin
        all_min = 1'b1;
        for (int k = 1; k <= NUM_LOCS; k++) begin
            if (mem[k].step_dwell_time != `OSPS_DWELL_MIN) begin
                all_min = 1'b0;
            end
        end
    end

    assign cur = mem[loc_ok(q.cur_loc) ? q.cur_loc : '0];
    assign wr_done = psel && penable && q.pready && pwrite;

    // The store has reset so every dwell starts at the minimum tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k <= NUM_LOCS; k++) begin
                mem[k].sp.vset <= `OSPS_DEF_VSET;
                mem[k].sp.iset <= `OSPS_DEF_ISET;
                mem[k].sp.overvoltage_limit <= `OSPS_DEF_OV;
                mem[k].sp.overcurrent_limit <= `OSPS_DEF_OC;
                mem[k].step_dwell_time <= `OSPS_DWELL_MIN;
                mem[k].next_loc <= '0;
            end
        end else begin
            if (we_setpt) begin
                mem[q.edit_loc].sp.vset <= pwdata[15:0];
                mem[q.edit_loc].sp.iset <= pwdata[31:16];
            end
            if (we_limit) begin
                mem[q.edit_loc].sp.overvoltage_limit <= pwdata[15:0];
                mem[q.edit_loc].sp.overcurrent_limit <= pwdata[31:16];
            end
            if (we_dwnxt) begin
                mem[q.edit_loc].step_dwell_time <= pwdata[15:0];
                mem[q.edit_loc].next_loc <=
                    pwdata[`OSPS_LOC_LSB +: `OSPS_LOC_W];
            end
        end
    end

    // Next-state logic: bus slave first, then the sequencer.
    always_comb begin
        d = q;
        d.cmd = '0;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        we_setpt = 1'b0;
        we_limit = 1'b0;
        we_dwnxt = 1'b0;
        load = 1'b0;
        load_loc = q.cur_loc;

        // One wait state: the answer is registered so pready and
        // prdata both come from flip-flops.
        if (psel && penable && !q.pready) begin
            d.pready = 1'b1;
            d.pslverr = !addr_ok(paddr) ||
                        (pwrite && wr_bad(paddr, pwdata));
            d.prdata = '0;
            case (paddr)
                `OSPS_STATUS_OFS: begin
                    d.prdata = {8'h00, 2'b00, q.cur_loc,
                                3'b000, q.out_en, q.stop_pend,
                                q.step_mode, 2'b00, 3'b000, q.state};
                end
                `OSPS_START_OFS: d.prdata = 32'(q.start_loc);
                `OSPS_EDIT_OFS: d.prdata = 32'(q.edit_loc);
                `OSPS_SETPT_OFS: begin
                    d.prdata = {mem[q.edit_loc].sp.iset,
                                mem[q.edit_loc].sp.vset};
                end
                `OSPS_LIMIT_OFS: begin
                    d.prdata = {mem[q.edit_loc].sp.overcurrent_limit,
                                mem[q.edit_loc].sp.overvoltage_limit};
                end
                `OSPS_DWNXT_OFS: begin
                    d.prdata = {10'h000, mem[q.edit_loc].next_loc,
                                mem[q.edit_loc].step_dwell_time};
                end
                default: d.prdata = '0;
            endcase
        end

        // Writes take effect on the edge that completes the access.
        if (wr_done && addr_ok(paddr) && !wr_bad(paddr, pwdata)) begin
            case (paddr)
                `OSPS_CMD_OFS: begin
                    d.cmd = pwdata[`OSPS_CMD_W-1:0];
                    d.cmd_loc = pwdata[`OSPS_LOC_LSB +: `OSPS_LOC_W];
                end
                `OSPS_START_OFS: begin
                    if (loc_ok(pwdata[`OSPS_LOC_W-1:0])) begin
                        d.start_loc = pwdata[`OSPS_LOC_W-1:0];
                    end
                end
                `OSPS_EDIT_OFS: begin
                    if (loc_ok(pwdata[`OSPS_LOC_W-1:0])) begin
                        d.edit_loc = pwdata[`OSPS_LOC_W-1:0];
                    end
                end
                `OSPS_SETPT_OFS: we_setpt = 1'b1;
                `OSPS_LIMIT_OFS: we_limit = 1'b1;
                `OSPS_DWNXT_OFS: we_dwnxt = 1'b1;
                default: ;
            endcase
        end

        // Tick timer runs only while a step dwells in a run.
        if (q.state == OSPS_RUN) begin
            d.tick = (q.tick == TICK_LAST) ? '0 : q.tick + 32'h1;
        end

        case (q.state)
            OSPS_IDLE: begin
                if (q.cmd[`OSPS_CMD_OUTTOG]) begin
                    d.out_en = !q.out_en;
                end else if (q.cmd[`OSPS_CMD_RUN] ||
                             q.cmd[`OSPS_CMD_STEP]) begin
                    d.state = OSPS_PROMPT;
                    d.step_mode = q.cmd[`OSPS_CMD_STEP];
                    d.prompt_loc = q.start_loc;
                end
            end
            OSPS_PROMPT: begin
                if (q.cmd[`OSPS_CMD_CLEAR]) begin
                    d.state = OSPS_IDLE;
                end else if (q.cmd[`OSPS_CMD_ENTER]) begin
                    load = 1'b1;
                    load_loc = loc_ok(q.cmd_loc) ? q.cmd_loc
                                                 : q.prompt_loc;
                    d.state = q.step_mode ? OSPS_STEP : OSPS_RUN;
                end
            end
            OSPS_RUN: begin
                if (q.cmd[`OSPS_CMD_OUTTOG]) begin
                    d.out_en = 1'b0;
                    d.state = OSPS_HALT;
                end else begin
                    if (q.cmd[`OSPS_CMD_CLEAR]) begin
                        d.stop_pend = 1'b1;
                    end
                    if (q.tick == TICK_LAST) begin
                        if (q.dwell > `OSPS_DWELL_MIN) begin
                            d.dwell = q.dwell - 16'h1;
                        end else if (q.stop_pend ||
                                     q.cmd[`OSPS_CMD_CLEAR]) begin
                            d.state = OSPS_IDLE;
                        end else if (cur.next_loc == '0) begin
                            d.state = OSPS_IDLE;
                        end else begin
                            load = 1'b1;
                            load_loc = cur.next_loc;
                        end
                    end
                end
            end
            OSPS_STEP: begin
                if (q.cmd[`OSPS_CMD_OUTTOG]) begin
                    d.out_en = !q.out_en;
                end else if (q.cmd[`OSPS_CMD_CLEAR]) begin
                    d.state = OSPS_IDLE;
                end else if (q.cmd[`OSPS_CMD_STEP]) begin
                    if (cur.next_loc == '0) begin
                        d.state = OSPS_IDLE;
                    end else begin
                        load = 1'b1;
                        load_loc = cur.next_loc;
                    end
                end
            end
            OSPS_HALT: begin
                // Set-points were never cleared, so re-enabling restores
                // the remembered step without resuming the sequence.
                if (q.cmd[`OSPS_CMD_OUTTOG]) begin
                    d.out_en = 1'b1;
                    d.state = OSPS_IDLE;
                end
            end
            default: d.state = OSPS_IDLE;
        endcase

        // Fetched here, once the chosen location is final, so the fetch
        // does not loop back through a separate continuous assignment.
        nxt = mem[loc_ok(load_loc) ? load_loc : '0];

        // Executing a location copies its set-points and dwell.
        if (load) begin
            d.cur_loc = load_loc;
            d.out = nxt.sp;
            d.dwell = nxt.step_dwell_time;
            d.tick = '0;
            d.stop_pend = 1'b0;
            d.disp.exec_loc = load_loc;
            d.disp.next_loc = nxt.next_loc;
        end

        // Reset wins over every other command in any state.
        if (q.cmd[`OSPS_CMD_RESET]) begin
            d.state = OSPS_IDLE;
            d.stop_pend = 1'b0;
            d.out.vset = `OSPS_DEF_VSET;
            d.out.iset = `OSPS_DEF_ISET;
            d.out.overvoltage_limit = `OSPS_DEF_OV;
            d.out.overcurrent_limit = `OSPS_DEF_OC;
            d.out_en = `OSPS_DEF_OUT_EN;
        end

        // Display follows measurements during run and step.
        d.disp.running_msg = (d.state == OSPS_RUN) && all_min;
        d.disp.local_ind = (d.state == OSPS_STEP);
        if (q.state == OSPS_RUN || q.state == OSPS_STEP) begin
            d.disp.meas = meas;
        end
    end

    // Every piece of control state lives in one registered struct.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.state <= OSPS_IDLE;
            q.start_loc <= `OSPS_START_RST;
            q.edit_loc <= `OSPS_START_RST;
            q.cur_loc <= `OSPS_START_RST;
            q.prompt_loc <= `OSPS_START_RST;
            q.dwell <= `OSPS_DWELL_MIN;
            q.out.vset <= `OSPS_DEF_VSET;
            q.out.iset <= `OSPS_DEF_ISET;
            q.out.overvoltage_limit <= `OSPS_DEF_OV;
            q.out.overcurrent_limit <= `OSPS_DEF_OC;
            q.out_en <= `OSPS_DEF_OUT_EN;
        end else begin
            q <= d;
        end
    end

    // Outputs are taken straight from the registered state.
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign out_setpt = q.out;
    assign out_enable = q.out_en;
    assign disp = q.disp;
    assign seq_state = q.state;

endmodule

`default_nettype wire

// ==== dv/osps_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Front-panel measurement path: a fresh reading every cycle.
module osps_panel_model
    import osps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    output osps_meas_t meas
);
    // A supply regulates in exactly one mode, so out of reset the two flags never agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas <= '0;
        end else begin
            meas <= {16'($urandom), 16'($urandom),
                     2'(2'b10 >> $urandom_range(1, 0))};
        end
    end
endmodule
`default_nettype wire

// ==== dv/osps_seq_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "osps_params.svh"
// Port-level checker for the sequencer.
module osps_seq_props
    import osps_pkg::*;
#(
    parameter int TICK_CYCLES = `OSPS_TICK_CYCLES,
    parameter int NUM_LOCS = `OSPS_NUM_LOCS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire osps_meas_t meas,
    input wire osps_setpt_t out_setpt,
    input wire logic out_enable,
    input wire osps_disp_t disp,
    input wire osps_state_t seq_state
);
    logic wr_cmd;
    logic [5:0] op;
    osps_setpt_t dflt;

    // Commands count only at the edge where the write completes.
    assign wr_cmd = psel && penable && pready && pwrite && paddr == 8'h00;
    assign op = pwdata[5:0];
    assign dflt = {`OSPS_DEF_OV, `OSPS_DEF_OC, `OSPS_DEF_ISET, `OSPS_DEF_VSET};

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PROMPT_CLEAR:
    assert property (seq_state == OSPS_PROMPT && wr_cmd && op == 6'h08 |->
        ##3 seq_state == OSPS_IDLE && out_setpt == $past(out_setpt, 3))
    else $error("clear at prompt did not abandon the run");
    AST_ENTER_STARTS:
    assert property (seq_state == OSPS_PROMPT && wr_cmd && op == 6'h04 |->
        ##3 seq_state inside {OSPS_RUN, OSPS_STEP})
    else $error("confirmation did not start execution");
    AST_STEP_LOCAL:
    assert property (seq_state == OSPS_STEP && $past(seq_state) == OSPS_STEP
        |-> disp.local_ind)
    else $error("local indicator missing in step mode");
    AST_MEAS_SHOWN:
    assert property ($past(seq_state) inside {OSPS_RUN, OSPS_STEP} &&
        seq_state inside {OSPS_RUN, OSPS_STEP} |-> disp.meas == $past(meas))
    else $error("display does not follow the measurement");
    AST_STEP_HOLDS:
    assert property ((seq_state == OSPS_STEP && !wr_cmd) [*3] |=>
        $stable(out_setpt))
    else $error("step mode advanced without a command");
    AST_TOGGLE_HALTS:
    assert property (seq_state == OSPS_RUN && wr_cmd && op == 6'h20 |->
        ##3 seq_state == OSPS_HALT && !out_enable)
    else $error("output toggle did not halt the run");
    AST_TOGGLE_RESUMES:
    assert property (seq_state == OSPS_HALT && wr_cmd && op == 6'h20 |->
        ##3 seq_state == OSPS_IDLE && out_enable)
    else $error("second toggle did not restore the output");
    AST_RESET_DEFAULTS:
    assert property (wr_cmd && pwdata[4] |-> ##3 seq_state == OSPS_IDLE &&
        out_enable && out_setpt == dflt)
    else $error("reset command did not restore defaults");
    AST_STEP_CLEAR:
    assert property (seq_state == OSPS_STEP && wr_cmd && op == 6'h08 |->
        ##3 seq_state == OSPS_IDLE && out_setpt == $past(out_setpt, 3))
    else $error("clear in step mode changed the output");
endmodule

bind osps_sequencer osps_seq_props #(.TICK_CYCLES(TICK_CYCLES),
    .NUM_LOCS(NUM_LOCS)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .out_setpt(out_setpt), .out_enable(out_enable),
    .disp(disp), .seq_state(seq_state));
`default_nettype wire

// ==== dv/output_step_program_sequencer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "osps_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module output_step_program_sequencer_test;
    import osps_pkg::*;
    // A 10 ms tick is shortened to four cycles to keep runs brief.
    localparam int TC = 4;
    localparam logic [5:0] RUN = 6'h01, STP = 6'h02, ENT = 6'h04;
    localparam logic [5:0] CLR = 6'h08, RST = 6'h10, TOG = 6'h20;
    localparam osps_setpt_t DFLT = {`OSPS_DEF_OV, `OSPS_DEF_OC,
        `OSPS_DEF_ISET, `OSPS_DEF_VSET};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic out_enable;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    osps_meas_t meas;
    osps_meas_t mv;
    osps_setpt_t out_setpt;
    osps_disp_t disp;
    osps_state_t seq_state;
    osps_setpt_t sp [1:3];
    logic [15:0] dw [1:3];
    int n_fail = 0;
    int n_tests = 0;
    int cnt;

    osps_sequencer #(.TICK_CYCLES(TC), .NUM_LOCS(40)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas(meas),
        .out_setpt(out_setpt), .out_enable(out_enable), .disp(disp),
        .seq_state(seq_state));
    osps_panel_model u_panel (.pclk(pclk), .presetn(presetn), .meas(meas));

    // Bench clock at 250 MHz.
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic stall(input string what);
        n_fail++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        complete_run();
    endtask

    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) stall("apb");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cmd(input logic [5:0] b, input logic [5:0] l);
        apb(1'b1, `OSPS_CMD_OFS, {10'h000, l, 10'h000, b});
    endtask

    task automatic prog(input int i, input logic [15:0] d, input int nx);
        apb(1'b1, `OSPS_EDIT_OFS, 32'(i));
        apb(1'b1, `OSPS_SETPT_OFS, {sp[i].iset, sp[i].vset});
        apb(1'b1, `OSPS_LIMIT_OFS, {sp[i][47:32], sp[i][63:48]});
        apb(1'b1, `OSPS_DWNXT_OFS, {10'h000, 6'(nx), d});
        dw[i] = d;
    endtask

    task automatic wait_st(input osps_state_t s);
        int k;
        for (k = 0; k < 400 && seq_state !== s; k++) @(posedge pclk);
        if (seq_state !== s) stall("state");
    endtask

    task automatic wait_sp(input osps_setpt_t s, output int k);
        for (k = 0; k < 400 && out_setpt !== s; k++) @(posedge pclk);
        if (out_setpt !== s) stall("set-point");
    endtask

    // Run or step request, confirmed at the given location.
    task automatic start(input logic [5:0] b, input logic [5:0] l);
        cmd(b, 6'h00);
        wait_st(OSPS_PROMPT);
        cmd(ENT, l);
    endtask

    initial begin
        void'($urandom(60393));
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `OSPS_START_OFS, 32'h0);
        `CHK("start", 32'h00000001, rd);
        apb(1'b0, `OSPS_DWNXT_OFS, 32'h0);
        `CHK("dwell", 32'h00000001, rd);
        apb(1'b0, 8'h1C, 32'h0);
        `CHK("unmapped", 1'b1, err);
        `CHK("output", DFLT, out_setpt);
        // Three random steps closed by a zero successor, then refusals.
        for (int i = 1; i <= 3; i++) begin
            sp[i] = {$urandom, $urandom};
            sp[i].vset[1:0] = 2'(i);
            prog(i, 16'($urandom_range(3, 2)), (i == 3) ? 0 : i + 1);
        end
        apb(1'b1, `OSPS_DWNXT_OFS, 32'h00020000);
        `CHK("zero dwell", 1'b1, err);
        apb(1'b1, `OSPS_DWNXT_OFS, 32'h00290001);
        `CHK("far successor", 1'b1, err);
        apb(1'b0, `OSPS_LIMIT_OFS, 32'h0);
        `CHK("limits", {sp[3][47:32], sp[3][63:48]}, rd);
        apb(1'b0, `OSPS_DWNXT_OFS, 32'h0);
        `CHK("dwell kept", {16'h0000, dw[3]}, rd);
        $display("test reset and store done");
        start(RUN, 6'h00);
        wait_st(OSPS_RUN);
        `CHK("first", sp[1], out_setpt);
        `CHK("message", 1'b0, disp.running_msg);
        wait_sp(sp[2], cnt);
        `CHK("dwell 1", dw[1] * TC, cnt);
        wait_sp(sp[3], cnt);
        `CHK("dwell 2", dw[2] * TC, cnt);
        wait_st(OSPS_IDLE);
        repeat (8 * TC) @(posedge pclk);
        `CHK("ended", {OSPS_IDLE, sp[3]}, {seq_state, out_setpt});
        cmd(STP, 6'h00);
        wait_st(OSPS_PROMPT);
        cmd(CLR, 6'h00);
        wait_st(OSPS_IDLE);
        `CHK("abandon", sp[3], out_setpt);
        $display("test run once done");
        // The offered location is now two and is confirmed as offered.
        apb(1'b1, `OSPS_START_OFS, 32'h00000002);
        start(STP, 6'h00);
        wait_st(OSPS_STEP);
        repeat (4 * TC) @(posedge pclk);
        `CHK("held", sp[2], out_setpt);
        `CHK("shown", 13'h1083, {disp.local_ind, disp.exec_loc,
            disp.next_loc});
        mv = meas;
        @(posedge pclk);
        `CHK("measured", mv, disp.meas);
        apb(1'b0, `OSPS_STATUS_OFS, 32'h0);
        `CHK("status", 32'h00021408, rd);
        cmd(TOG, 6'h00);
        repeat (2) @(posedge pclk);
        `CHK("off", {1'b0, OSPS_STEP}, {out_enable, seq_state});
        cmd(TOG, 6'h00);
        cmd(STP, 6'h00);
        wait_sp(sp[3], cnt);
        cmd(CLR, 6'h00);
        wait_st(OSPS_IDLE);
        `CHK("kept", {1'b1, sp[3]}, {out_enable, out_setpt});
        $display("test single step done");
        // Minimum dwell everywhere and a successor back to the start.
        for (int i = 1; i <= 3; i++) begin
            prog(i, 16'h0001, i % 3 + 1);
        end
        start(RUN, 6'h01);
        wait_st(OSPS_RUN);
        wait_sp(sp[2], cnt);
        wait_sp(sp[3], cnt);
        wait_sp(sp[1], cnt);
        `CHK("loop", TC, cnt);
        `CHK("message", 1'b1, disp.running_msg);
        cmd(RST, 6'h00);
        repeat (2) @(posedge pclk);
        `CHK("reset", {OSPS_IDLE, 1'b1, DFLT},
            {seq_state, out_enable, out_setpt});
        $display("test loop done");
        prog(2, 16'h0028, 3);
        start(RUN, 6'h02);
        wait_st(OSPS_RUN);
        cmd(CLR, 6'h00);
        repeat (2) @(posedge pclk);
        `CHK("finishing", OSPS_RUN, seq_state);
        wait_st(OSPS_IDLE);
        `CHK("stopped", sp[2], out_setpt);
        start(RUN, 6'h02);
        wait_st(OSPS_RUN);
        cmd(TOG, 6'h00);
        repeat (50 * TC) @(posedge pclk);
        `CHK("halt", {1'b0, OSPS_HALT}, {out_enable, seq_state});
        cmd(TOG, 6'h00);
        repeat (2) @(posedge pclk);
        `CHK("restore", {1'b1, OSPS_IDLE, sp[2]},
            {out_enable, seq_state, out_setpt});
        $display("test stopping done");
        complete_run();
    end
endmodule
`default_nettype wire
